// ===== design/rsc_reset_source_controller.sv
// Reset source controller: gathers reset requests, sequences reset, records the cause
//
// Contract
// - Reset halts the core, loads SFR defaults, forces ports, disables interrupts and timers.
// - Data memory is not reset; only the stack pointer returns to default.
// - During reset port latches read 0xFF open-drain; weak pull-ups stay on always.
// - Power-on and supply-monitor resets drive the reset pin low until release.
// - On release the program counter clears and the internal oscillator is selected.
// - On release the watchdog is enabled, clocked at system clock over twelve.
// - First fetch after release comes from address zero.
// - Bit 6 is read-only, set when a flash fault caused the last reset.
// - Bit 5 write enables comparator reset; read shows comparator caused last reset.
// - Writing 1 to bit 4 forces reset at once; bit 4 then reads 1.
// - Bit 3 is read-only, set when a watchdog overflow caused the last reset.
// - Bit 2 write enables clock loss detector reset; read shows it caused last reset.
// - Bit 1 write enables supply monitor reset; software enables monitor first.
// - Bit 1 reads 1 after power-on or supply reset; other flags then undefined.
// - Bit 0 is read-only, set when the external reset pin caused the last reset.
// - Bit 7 reads 0, writes ignored; software avoids read-modify-write on it.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module rsc_reset_source_controller (
	input  wire logic        clk_i,             // System clock, 20 MHz
	input  wire logic        reset_n_i,         // Power-on reset, active low
	input  wire logic [7:0]  addr_i,            // Register address
	input  wire logic [7:0]  wdata_i,           // Register write data
	input  wire logic        wr_i,              // Write strobe
	input  wire logic        rd_i,              // Read strobe
	output logic      [7:0]  rdata_o,           // Read data, cycle after strobe
	input  wire logic        rst_pin_i,         // Reset pin level
	output logic             rst_pin_o,         // Reset pin drive value
	output logic             rst_pin_oe_o,      // Reset pin drive enable
	input  wire logic        supply_low_i,      // Supply monitor trip
	input  wire logic        watchdog_ovf_i,    // Watchdog overflow pulse
	input  wire logic        clock_missing_i,   // Clock loss detector trip
	input  wire logic        comparator_n_i,    // Comparator output, active low
	input  wire logic        flash_fault_i,     // Flash access error
	output logic             core_halt_o,       // Core stopped
	output logic             sfr_reset_o,       // Load SFR reset values
	output logic             irq_timer_off_o,   // Interrupts and timers disabled
	output logic [7:0]       port_latch_o,      // Port latch value under reset
	output logic             port_force_o,      // Port latches forced
	output logic             port_open_drain_o, // Ports in open-drain mode
	output logic             weak_pullup_en_o,  // Weak pull-ups enabled
	output logic             pc_clear_o,        // Clear program counter, pulse
	output logic [15:0]      boot_addr_o,       // First fetch address
	output logic             fetch_start_o,     // Start execution, pulse
	output logic             clk_sel_int_o,     // Select internal oscillator, pulse
	output logic             wdt_enable_o,      // Watchdog enabled
	output logic             wdt_tick_o,        // Watchdog clock, sysclk/12
	output logic             irq_o              // Interrupt, level
);
	rsc_pkg::rsc_state_e state;
	rsc_pkg::rsc_state_e next_state;
	logic [3:0]  hold_cnt;
	logic [3:0]  wdt_div;
	logic [6:0]  cause;
	logic [6:0]  next_cause;
	logic [6:0]  irq_stat;
	logic [6:0]  irq_mask;
	logic        cmp_en;
	logic        mcd_en;
	logic        sup_en;
	logic        sw_force;
	logic        drive_pin;
	logic        pin_req;
	logic        sup_req;
	logic        any_req;
	logic        hold_done;
	logic        wr_cause;

	// Decoded strobes and next values
	logic        wr_stat;
	logic        wr_mask;
	logic        in_run;
	logic        in_hold;
	logic        in_start;
	logic [3:0]  next_hold_cnt;
	logic [3:0]  next_wdt_div;
	logic [6:0]  stat_clr;
	logic [6:0]  stat_set;
	logic [6:0]  next_irq_stat;

	// Write strobe aimed at one register address
	function automatic logic wr_hit(
		input logic       wr,    // Write strobe
		input logic [7:0] addr,  // Bus address
		input logic [7:0] target // Register address
	);
		wr_hit = wr && (addr == target);
	endfunction

	// One cause flag only; supply outranks the pin so a brown-out is never hidden.
	// Flash, watchdog and the pin are ungated; supply, clock loss and comparator need their enable.
	function automatic logic [6:0] pick_cause(
		input logic sup,   // Supply monitor request
		input logic pin,   // Reset pin request
		input logic flash, // Flash fault
		input logic wdt,   // Watchdog overflow
		input logic clock_loss_detector,   // Enabled clock loss trip
		input logic cmp,   // Enabled comparator trip
		input logic sw     // Software force
	);
		pick_cause = '0;
		if (sup) begin
			pick_cause[rsc_pkg::POR_BIT] = 1'b1;
		end else if (pin) begin
			pick_cause[rsc_pkg::PIN_BIT] = 1'b1;
		end else if (flash) begin
			pick_cause[rsc_pkg::FLASH_BIT] = 1'b1;
		end else if (wdt) begin
			pick_cause[rsc_pkg::WDT_BIT] = 1'b1;
		end else if (clock_loss_detector) begin
			pick_cause[rsc_pkg::MCD_BIT] = 1'b1;
		end else if (cmp) begin
			pick_cause[rsc_pkg::CMP_BIT] = 1'b1;
		end else if (sw) begin
			pick_cause[rsc_pkg::SW_BIT] = 1'b1;
		end
	endfunction

	// Read value of a mapped register; enables read back as flags, bit 7 as zero
	function automatic logic [7:0] read_word(
		input logic [7:0] addr,  // Bus address
		input logic [6:0] flags, // Cause flags
		input logic [6:0] stat,  // Interrupt status
		input logic [6:0] mask   // Interrupt mask
	);
		case (addr)
			rsc_pkg::CAUSE_ADDR: begin
				read_word = {1'b0, flags};
			end
			rsc_pkg::IRQ_STAT_ADDR: begin
				read_word = {1'b0, stat};
			end
			rsc_pkg::IRQ_MASK_ADDR: begin
				read_word = {1'b0, mask};
			end
			default: begin
				read_word = 8'h00;
			end
		endcase
	endfunction

	// State decodes, shared by sequencing and outputs
	assign in_run   = (state == rsc_pkg::RSC_RUN);
	assign in_hold  = (state == rsc_pkg::RSC_HOLD);
	assign in_start = (state == rsc_pkg::RSC_START);

	// Cause register writes count only while running
	assign wr_cause = wr_hit(wr_i, addr_i, rsc_pkg::CAUSE_ADDR) && in_run;
	assign wr_stat  = wr_hit(wr_i, addr_i, rsc_pkg::IRQ_STAT_ADDR);
	assign wr_mask  = wr_hit(wr_i, addr_i, rsc_pkg::IRQ_MASK_ADDR);

	// Pin is ignored while we pull it ourselves, else our own drive would look like a pin reset
	assign pin_req = !rst_pin_i && !drive_pin;
	assign sup_req = sup_en && supply_low_i;
	assign sw_force = wr_cause && wdata_i[rsc_pkg::SW_BIT];

	assign next_cause = pick_cause(
		sup_req,
		pin_req,
		flash_fault_i,
		watchdog_ovf_i,
		mcd_en && clock_missing_i,
		cmp_en && !comparator_n_i,
		sw_force
	);

	assign any_req = |next_cause;
	assign hold_done = (hold_cnt == rsc_pkg::HOLD_LAST) && !pin_req && !sup_req;

	always_comb begin
		case (state)
			rsc_pkg::RSC_RUN: begin
				next_state = any_req ? rsc_pkg::RSC_HOLD : rsc_pkg::RSC_RUN;
			end
			rsc_pkg::RSC_HOLD: begin
				next_state = hold_done ? rsc_pkg::RSC_START : rsc_pkg::RSC_HOLD;
			end
			rsc_pkg::RSC_START: begin
				next_state = any_req ? rsc_pkg::RSC_HOLD : rsc_pkg::RSC_RUN;
			end
			default: begin
				next_state = rsc_pkg::RSC_HOLD;
			end
		endcase
	end

	// Power-up enters hold, so the start sequence also follows power-on
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= rsc_pkg::RSC_HOLD;
		end else begin
			state <= next_state;
		end
	end

	// Hold length restarts while a level source stays asserted.
	// The count only ends with the pin released and the supply good,
	// so a held button stretches the reset for as long as it is pressed.
	always_comb begin
		next_hold_cnt = hold_cnt;
		if (!in_hold || pin_req || sup_req) begin
			next_hold_cnt = '0;
		end else if (hold_cnt != rsc_pkg::HOLD_LAST) begin
			next_hold_cnt = hold_cnt + 4'h1;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hold_cnt <= '0;
		end else begin
			hold_cnt <= next_hold_cnt;
		end
	end

	// Cause flags; a later request in hold leaves the earlier one in place.
	// Only a supply trip may overwrite inside hold, so the flag names
	// what started the reset and not what happened while it lasted.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cause <= rsc_pkg::CAUSE_POR_RST;
		end else if (state != rsc_pkg::RSC_HOLD && any_req) begin
			cause <= next_cause;
		end else if (state == rsc_pkg::RSC_HOLD && sup_req) begin
			cause <= next_cause;
		end
	end

	// Power-on pin drive, held until the start cycle.
	// Released on the edge into start, so the pin rises with the start pulse
	// and the pin request never sees our own drive as a button press.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			drive_pin <= 1'b1;
		end else if (next_state == rsc_pkg::RSC_HOLD && sup_req) begin
			drive_pin <= 1'b1;
		end else if (next_state != rsc_pkg::RSC_HOLD) begin
			drive_pin <= 1'b0;
		end
	end

	// Comparator enable is an ordinary register bit, cleared by any reset
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cmp_en <= 1'b0;
		end else if (in_hold) begin
			cmp_en <= 1'b0;
		end else if (wr_cause) begin
			cmp_en <= wdata_i[rsc_pkg::CMP_BIT];
		end
	end

	// Clock loss enable, likewise cleared by any reset
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mcd_en <= 1'b0;
		end else if (in_hold) begin
			mcd_en <= 1'b0;
		end else if (wr_cause) begin
			mcd_en <= wdata_i[rsc_pkg::MCD_BIT];
		end
	end

	// Supply enable survives so a brown-out still guards the restart.
	// A trip is taken at once, so software sets it only with the monitor stable.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sup_en <= 1'b0;
		end else if (wr_cause) begin
			sup_en <= wdata_i[rsc_pkg::POR_BIT];
		end
	end

	// Interrupt status: each release posts the cause of that reset, power-on included.
	// A one written clears a bit, but a post in the same cycle wins so no event is lost.
	assign stat_clr      = wr_stat ? wdata_i[6:0] : 7'h00;
	assign stat_set      = in_start ? cause : 7'h00;
	assign next_irq_stat = (irq_stat & ~stat_clr) | stat_set;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			irq_stat <= '0;
		end else begin
			irq_stat <= next_irq_stat;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			irq_mask <= rsc_pkg::IRQ_MASK_RST;
		end else if (wr_mask) begin
			irq_mask <= wdata_i[6:0];
		end
	end

	assign irq_o = |(irq_stat & irq_mask);

	// Read data stand one cycle after the strobe, zero otherwise
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			rdata_o <= read_word(addr_i, cause, irq_stat, irq_mask);
		end else begin
			rdata_o <= 8'h00;
		end
	end

	// Watchdog runs after release from sysclk/12
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wdt_enable_o <= 1'b0;
		end else begin
			wdt_enable_o <= (next_state == rsc_pkg::RSC_RUN);
		end
	end

	// Divider counts only in run; any reset restarts the period
	always_comb begin
		next_wdt_div = wdt_div + 4'h1;
		if (!in_run || wdt_div == rsc_pkg::WDT_DIV_LAST) begin
			next_wdt_div = '0;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wdt_div <= '0;
		end else begin
			wdt_div <= next_wdt_div;
		end
	end

	assign wdt_tick_o = (state == rsc_pkg::RSC_RUN) && (wdt_div == rsc_pkg::WDT_DIV_LAST);

	// Reset state outputs; data memory has no reset, stack pointer reloads via sfr_reset_o
	assign core_halt_o       = (state != rsc_pkg::RSC_RUN);
	assign sfr_reset_o       = (state == rsc_pkg::RSC_HOLD);
	assign irq_timer_off_o   = (state == rsc_pkg::RSC_HOLD);
	assign port_force_o      = (state == rsc_pkg::RSC_HOLD);
	assign port_open_drain_o = (state == rsc_pkg::RSC_HOLD);
	assign weak_pullup_en_o  = 1'b1;

	// Pin is only ever pulled low, never driven high
	assign rst_pin_o         = 1'b0;
	assign rst_pin_oe_o      = drive_pin;

	// Start pulses last the single start cycle
	assign pc_clear_o        = in_start;
	assign clk_sel_int_o     = in_start;
	assign fetch_start_o     = in_start;

	// Data outputs come from flops, loaded with fixed values
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			port_latch_o <= rsc_pkg::PORT_LATCH_RST;
		end else begin
			port_latch_o <= rsc_pkg::PORT_LATCH_RST;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			boot_addr_o <= rsc_pkg::BOOT_ADDR;
		end else begin
			boot_addr_o <= rsc_pkg::BOOT_ADDR;
		end
	end
endmodule // rsc_reset_source_controller

// ===== design/rsc_pkg.sv
// Constants and types shared by the reset source controller
package rsc_pkg;
	// Register offsets
	localparam logic [7:0] CAUSE_ADDR     = 8'hEF;
	localparam logic [7:0] IRQ_STAT_ADDR  = 8'hF5;
	localparam logic [7:0] IRQ_MASK_ADDR  = 8'hF6;

	// Field positions of the cause and enable register
	localparam int PIN_BIT   = 0;
	localparam int POR_BIT   = 1;
	localparam int MCD_BIT   = 2;
	localparam int WDT_BIT   = 3;
	localparam int SW_BIT    = 4;
	localparam int CMP_BIT   = 5;
	localparam int FLASH_BIT = 6;
	localparam int CAUSE_W   = 7;

	// Reset values
	localparam logic [6:0] CAUSE_POR_RST  = 7'h02;
	localparam logic [6:0] IRQ_MASK_RST   = 7'h00;
	localparam logic [7:0] PORT_LATCH_RST = 8'hFF;
	localparam logic [15:0] BOOT_ADDR     = 16'h0000;

	// Timing
	localparam int CLK_PERIOD_NS  = 50;
	localparam int RESET_HOLD_NS  = 500;
	localparam int HOLD_CYCLES    = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] HOLD_LAST = 4'(HOLD_CYCLES - 1);
	localparam int WDT_DIV        = 12;
	localparam logic [3:0] WDT_DIV_LAST = 4'(WDT_DIV - 1);

	typedef enum logic [2:0] {
		RSC_RUN   = 3'h1,
		RSC_HOLD  = 3'h2,
		RSC_START = 3'h4
	} rsc_state_e;
endpackage

// ===== bench/rsc_chk.sv
// Concurrent checks on the reset source controller ports
`timescale 1ns/1ps
module rsc_chk (
	input wire logic        clk_i,             // Clock
	input wire logic        reset_n_i,         // Reset
	input wire logic [7:0]  addr_i,            // Address
	input wire logic [7:0]  wdata_i,           // Write data
	input wire logic        wr_i,              // Write strobe
	input wire logic        rd_i,              // Read strobe
	input wire logic [7:0]  rdata_o,           // Read data
	input wire logic        rst_pin_i,         // Pin level
	input wire logic        rst_pin_o,         // Pin value
	input wire logic        rst_pin_oe_o,      // Pin enable
	input wire logic        watchdog_ovf_i,    // Overflow
	input wire logic        flash_fault_i,     // Flash error
	input wire logic        core_halt_o,       // Halt
	input wire logic        sfr_reset_o,       // Register load
	input wire logic        irq_timer_off_o,   // Timers off
	input wire logic        port_force_o,      // Port force
	input wire logic        port_open_drain_o, // Open drain
	input wire logic        pc_clear_o,        // Counter clear
	input wire logic        fetch_start_o,     // Fetch start
	input wire logic        clk_sel_int_o,     // Oscillator select
	input wire logic [15:0] boot_addr_o,       // Boot address
	input wire logic        wdt_enable_o,      // Watchdog on
	input wire logic        wdt_tick_o         // Watchdog tick
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	chk_hold_outputs: assert property (
		sfr_reset_o |-> core_halt_o && irq_timer_off_o && port_force_o && port_open_drain_o)
		else $error("hold outputs incomplete");
	chk_hold_length: assert property (
		$rose(sfr_reset_o) |-> sfr_reset_o[*8] ##1 sfr_reset_o[*2]) else $error("reset hold too short");
	chk_pin_drive: assert property (
		rst_pin_oe_o |-> !rst_pin_o && sfr_reset_o) else $error("pin driven outside reset");
	chk_start_pulse: assert property (
		$fell(sfr_reset_o) |-> pc_clear_o && fetch_start_o && clk_sel_int_o && boot_addr_o == 16'h0000
		##1 !pc_clear_o && !core_halt_o) else $error("start pulse wrong");
	chk_wdt_enable: assert property (
		wdt_enable_o == !core_halt_o) else $error("watchdog enable wrong");
	// A reset in mid-period restarts the divider, so it suspends the check
	chk_wdt_period: assert property (
		disable iff (!reset_n_i || sfr_reset_o) wdt_tick_o |-> ##12 wdt_tick_o) else $error("tick period wrong");
	chk_sw_force: assert property (
		wr_i && addr_i == rsc_pkg::CAUSE_ADDR && wdata_i[4] && !core_halt_o |=> sfr_reset_o)
		else $error("software reset missed");
	chk_source_reset: assert property (
		(watchdog_ovf_i || flash_fault_i || !rst_pin_i) && !core_halt_o |=> sfr_reset_o)
		else $error("source reset missed");
	chk_cause_read: assert property (
		rd_i && addr_i == rsc_pkg::CAUSE_ADDR |=> !rdata_o[7] && $onehot0(rdata_o[6:0]))
		else $error("cause read wrong");
	cover property (pc_clear_o && $past(rst_pin_oe_o));
	cover property ($rose(sfr_reset_o) && $past(wr_i));
	cover property (wdt_tick_o);
endmodule // rsc_chk

// ===== bench/rsc_pin_model.sv
// Reset pin wire with pull-up, shared by a push button and the block
`timescale 1ns/1ps
module rsc_pin_model (
	input  wire logic button_i,  // Button pressed
	input  wire logic pin_val_i, // Block drive value
	input  wire logic pin_oe_i,  // Block drive enable
	output logic      pin_o      // Wire level
);
	assign pin_o = !(button_i || (pin_oe_i && !pin_val_i)); // Pull-up when released
endmodule // rsc_pin_model

// ===== bench/tb.sv
// Self-checking bench for the reset source controller
`timescale 1ns/1ps
module tb;
	logic clk_i = 0, reset_n_i = 0, wr_i = 0, rd_i = 0, button = 0, supply_low_i = 0, watchdog_ovf_i = 0;
	logic clock_missing_i = 0, comparator_n_i = 1, flash_fault_i = 0, rst_pin_i, rst_pin_o, rst_pin_oe_o;
	logic core_halt_o, sfr_reset_o, irq_timer_off_o, port_force_o, port_open_drain_o, weak_pullup_en_o;
	logic pc_clear_o, fetch_start_o, clk_sel_int_o, wdt_enable_o, wdt_tick_o, irq_o, seen_oe, seen_pc;
	logic [7:0] addr_i = 0, wdata_i = 0, rdata_o, port_latch_o, rv;
	logic [15:0] boot_addr_o;
	int errors = 0, compares = 0, cyc, cnt, b;
	always #25 clk_i = ~clk_i;
	rsc_reset_source_controller DUT (.*);
	rsc_pin_model PIN (.button_i(button), .pin_val_i(rst_pin_o), .pin_oe_i(rst_pin_oe_o), .pin_o(rst_pin_i));
	task chk(input logic [15:0] seen, exp, input string what);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task wr(input logic [7:0] a, d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		rv = rdata_o;
	endtask
	task pulse(input int s);
		@(posedge clk_i);
		case (s)
			0: button <= 1'b1;
			1: supply_low_i <= 1'b1;
			2: clock_missing_i <= 1'b1;
			3: watchdog_ovf_i <= 1'b1;
			5: comparator_n_i <= 1'b0;
			6: flash_fault_i <= 1'b1;
			default: ;
		endcase
		@(posedge clk_i);
		{button, supply_low_i, clock_missing_i, watchdog_ovf_i, flash_fault_i} <= 5'h00;
		comparator_n_i <= 1'b1;
	endtask
	// Bounded wait for release, noting pin drive and start pulse on the way
	task wait_run;
		cyc = 0;
		seen_oe = 0;
		seen_pc = 0;
		do begin
			@(negedge clk_i);
			seen_oe |= rst_pin_oe_o;
			seen_pc |= pc_clear_o;
			cyc++;
		end while (core_halt_o !== 1'b0 && cyc < 100);
		chk(seen_pc, 1, "start pulse");
	endtask
	task print_verdict;
		$display("comparisons %0d mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#200000;
		errors++;
		print_verdict();
	end
	initial begin
		repeat (4) @(posedge clk_i);
		reset_n_i <= 1'b1;
		wait_run();
		chk(seen_oe, 1, "pin drive");
		chk({port_latch_o, 7'h00, weak_pullup_en_o}, 16'hFF01, "port state");
		rd(rsc_pkg::CAUSE_ADDR);
		chk(rv, 8'h02, "power-on cause");
		rd(8'h00);
		chk(rv, 8'h00, "unmapped read");
		rd(rsc_pkg::IRQ_MASK_ADDR);
		chk(rv, 8'h00, "mask reset");
		cnt = 0;
		repeat (24) @(negedge clk_i) cnt += wdt_tick_o;
		chk(cnt, 2, "watchdog ticks");
		$display("test power_on done");
		pulse(2);
		pulse(5);
		@(negedge clk_i);
		chk(core_halt_o, 0, "disabled sources");
		for (b = 0; b < 7; b++) begin
			wr(rsc_pkg::IRQ_STAT_ADDR, 8'h7F);
			if (b == 1 || b == 2 || b == 5)
				wr(rsc_pkg::CAUSE_ADDR, 8'h01 << b);
			if (b == 4)
				wr(rsc_pkg::CAUSE_ADDR, 8'h90);
			else
				pulse(b);
			wait_run();
			chk(cyc, rsc_pkg::HOLD_CYCLES + 2, "hold span");
			chk(seen_oe, b == 1, "pin drive");
			rd(rsc_pkg::CAUSE_ADDR);
			chk(rv, 8'h01 << b, "cause");
			rd(rsc_pkg::IRQ_STAT_ADDR);
			chk(rv, 8'h01 << b, "status");
		end
		$display("test sources done");
		wr(rsc_pkg::CAUSE_ADDR, 8'hA4);
		rd(rsc_pkg::CAUSE_ADDR);
		chk(rv, 8'h40, "enables hidden");
		wr(rsc_pkg::IRQ_MASK_ADDR, 8'h40);
		rd(rsc_pkg::IRQ_MASK_ADDR);
		chk(rv, 8'h40, "mask");
		chk(irq_o, 1, "irq raised");
		wr(rsc_pkg::IRQ_STAT_ADDR, 8'h40);
		@(negedge clk_i);
		chk(irq_o, 0, "irq cleared");
		$display("test registers done");
		print_verdict();
	end
endmodule // tb
bind rsc_reset_source_controller rsc_chk CHK (.*);
